// ===== src/eds_setup_core.sv
// Setup command logic of the panel driver: host port, settings, detections,
// temperature sensor master and cascade role.
// Assumes host_sclk is the host's port clock, idle outside frames.
// Operation
// - Single open-drain master on sensor bus
// - Top bit clear: positive, value over sixteen
// - Top bit set: negative, two's complement magnitude
// - Strap high master, low slave
// - Slave disables oscillator, booster; uses shared clock
// - Supply detection holds busy, drops when done
// - Supply result bit: 1 means below threshold
// - Rails detection holds busy; 1 means not ready
// - Gate level code 03h-17h valid
// - Three source bytes, reset 41h A8h 32h
// - Positive level bit7 set: 8Eh-CEh valid
// - Positive level bit7 clear: 23h-4Bh valid
// - Negative level even 1Ah-3Eh valid
// - Soft start takes three phases plus duration
// - Phase bits 6:4 select drive strength
// - Phase bits 3:0 off time, below 4 invalid
// - Duration byte fields for phases three-two-one
// - Duration code gives 10 to 40 ms
// - Supply threshold code, reset 100
`timescale 1ns/1ps
module eds_setup_core #(
  parameter int DETECT_N = eds_pkg::DETECT_CYCLES,
  parameter int QTR_N = eds_pkg::SCL_QTR_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Host serial port
  input wire logic host_sclk,
  input wire logic host_cs_n,
  input wire logic host_dc,
  input wire logic host_sdi,
  output logic host_sdo,
  // Cascade role
  input wire logic master_strap,
  output logic shared_osc_clock_pin_out,
  output logic shared_osc_clock_pin_oe_n,
  output logic osc_enable,
  output logic booster_enable,
  output logic clock_from_pin,
  // Sensor bus, open drain
  input wire logic sensor_bus_clock_in,
  output logic sensor_bus_clock_out,
  output logic sensor_bus_clock_oe_n,
  input wire logic sensor_bus_data_in,
  output logic sensor_bus_data_out,
  output logic sensor_bus_data_oe_n,
  // Analog detector results
  input wire logic supply_below_thr,
  input wire logic rails_ready,
  output logic busy,
  // Settings
  output logic [8:0] gate_line_count,
  output logic [2:0] gate_scan_bits,
  output logic [4:0] gate_high_level,
  output logic [7:0] source_pos_level_a,
  output logic [7:0] source_pos_level_b,
  output logic [7:0] source_neg_level,
  output logic [2:0] supply_threshold,
  output logic [4:0] setting_valid,
  output wire logic [8:0] ss_strength,
  output wire logic [11:0] ss_off_time,
  output wire logic [2:0] ss_off_valid,
  output wire logic [17:0] ss_duration_ms,
  // Temperature
  output logic temp_negative,
  output logic [11:0] temp_magnitude
);
  import eds_pkg::*;

  typedef enum logic {D_IDLE, D_RUN} eds_det_t;
  typedef enum logic [1:0] {I_IDLE, I_START, I_BIT, I_STOP} eds_i2c_t;
  localparam int DET_N = DETECT_N;

  // Host port, link side
  logic spi_rst_n; // Frame end clears bit count
  logic [2:0] bcnt_reg, bcnt_next;
  logic [6:0] shin_reg, shin_next;
  logic [7:0] rx_byte_reg, rx_byte_next;
  logic rx_dc_reg, rx_dc_next;
  logic rx_tgl_reg, rx_tgl_next;
  logic [7:0] out_sh_reg, out_sh_next;
  logic sdo_reg, sdo_next;
  logic [1:0] stat_l1_reg, stat_l2_reg; // Status into link domain
  // Core side synchronisers
  logic tg_s1, tg_s2, tg_s3, new_byte;
  logic strap_s1, strap_s2, low_s1, low_s2, rdy_s1, rdy_s2, sda_s1, sda_s2;
  logic scl_s1, scl_s2; // Read back only for completeness of the pin
  // Cascade role
  logic [1:0] cap_reg, cap_next;
  logic role_reg, role_next, div_reg, div_next;
  // Parser and settings
  logic [7:0] cmd_reg, cmd_next;
  logic [2:0] pidx_reg, pidx_next;
  logic [8:0] lines_next;
  logic [2:0] scan_next;
  logic [4:0] glev_next;
  logic [7:0] src_a_next, src_b_next, src_n_next;
  logic [2:0] thr_next;
  logic [7:0] ss_reg [4];
  logic [7:0] ss_next [4];
  logic [4:0] valid_next;
  logic start_ok, go_supply, go_rails, go_temp;
  // Detection
  eds_det_t det_reg, det_next;
  logic kind_reg, kind_next; // High selects rails check
  logic [15:0] dcnt_reg, dcnt_next;
  logic [1:0] stat_reg, stat_next;
  // Sensor master
  eds_i2c_t i2c_reg, i2c_next;
  logic [15:0] qcnt_reg, qcnt_next;
  logic [1:0] ph_reg, ph_next;
  logic [4:0] slot_reg, slot_next;
  logic [15:0] rsh_reg, rsh_next;
  logic sda_oe_n_reg, sda_oe_n_next, scl_oe_n_reg, scl_oe_n_next;
  logic tneg_next;
  logic [11:0] tmag_next, traw;
  logic [7:0] addr_byte;
  logic busy_reg, busy_next;

  assign spi_rst_n = resetn & ~host_cs_n;

  // Link side shift-in; toggle hands a whole byte to the core
  always_comb begin
    bcnt_next = bcnt_reg + 3'h1;
    shin_next = {shin_reg[5:0], host_sdi};
    rx_byte_next = rx_byte_reg;
    rx_dc_next = rx_dc_reg;
    rx_tgl_next = rx_tgl_reg;
    out_sh_next = {out_sh_reg[6:0], 1'b0};
    sdo_next = out_sh_reg[6];
    if (bcnt_reg == 3'h7) begin
      rx_byte_next = {shin_reg, host_sdi};
      rx_dc_next = host_dc;
      rx_tgl_next = ~rx_tgl_reg;
      // Status read answers in the next byte
      if (!host_dc && {shin_reg, host_sdi} == CMD_STATUS_READ) begin
        out_sh_next = {6'h00, stat_l2_reg};
        sdo_next = 1'b0;
      end
    end
  end

  // Bit count lives only within a frame
  always_ff @(posedge host_sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      bcnt_reg <= 3'h0;
      shin_reg <= 7'h00;
    end else begin
      bcnt_reg <= bcnt_next;
      shin_reg <= shin_next;
    end
  end

  // Held byte and read shifter survive frame ends
  always_ff @(posedge host_sclk or negedge resetn) begin
    if (!resetn) begin
      rx_byte_reg <= 8'h00;
      rx_dc_reg <= 1'b0;
      rx_tgl_reg <= 1'b0;
      out_sh_reg <= 8'h00;
      sdo_reg <= 1'b0;
      stat_l1_reg <= 2'h0;
      stat_l2_reg <= 2'h0;
    end else begin
      rx_byte_reg <= rx_byte_next;
      rx_dc_reg <= rx_dc_next;
      rx_tgl_reg <= rx_tgl_next;
      out_sh_reg <= out_sh_next;
      sdo_reg <= sdo_next;
      stat_l1_reg <= stat_reg;
      stat_l2_reg <= stat_l1_reg;
    end
  end

  // Two-flop synchronisers for the core
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {tg_s1, tg_s2, tg_s3} <= 3'h0;
      {strap_s1, strap_s2, low_s1, low_s2} <= 4'h0;
      {rdy_s1, rdy_s2, sda_s1, sda_s2, scl_s1, scl_s2} <= 6'h3F;
    end else begin
      {tg_s1, tg_s2, tg_s3} <= {rx_tgl_reg, tg_s1, tg_s2};
      {strap_s1, strap_s2} <= {master_strap, strap_s1};
      {low_s1, low_s2} <= {supply_below_thr, low_s1};
      {rdy_s1, rdy_s2} <= {rails_ready, rdy_s1};
      {sda_s1, sda_s2} <= {sensor_bus_data_in, sda_s1};
      {scl_s1, scl_s2} <= {sensor_bus_clock_in, scl_s1};
    end
  end
  assign new_byte = tg_s2 ^ tg_s3;

  // Strap caught once after the synchroniser settles
  always_comb begin
    cap_next = cap_reg;
    role_next = role_reg;
    if (cap_reg != 2'h3) begin
      cap_next = cap_reg + 2'h1;
      if (cap_reg == 2'h2) begin
        role_next = strap_s2;
      end
    end
    div_next = role_reg & ~div_reg; // Master drives clock out
  end

  // Role outputs; reset leaves pin released, sources off
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cap_reg <= 2'h0;
      role_reg <= 1'b0;
      div_reg <= 1'b0;
      osc_enable <= 1'b0;
      booster_enable <= 1'b0;
      clock_from_pin <= 1'b0;
      shared_osc_clock_pin_oe_n <= 1'b1;
    end else begin
      cap_reg <= cap_next;
      role_reg <= role_next;
      div_reg <= div_next;
      osc_enable <= role_next;
      booster_enable <= role_next;
      clock_from_pin <= ~role_next & (cap_next == 2'h3);
      shared_osc_clock_pin_oe_n <= ~role_next;
    end
  end
  assign shared_osc_clock_pin_out = div_reg;

  // Starts are refused while a job runs
  assign start_ok = new_byte & ~rx_dc_reg & ~busy_reg;
  assign go_supply = start_ok & (rx_byte_reg == CMD_SUPPLY_DETECT);
  assign go_rails = start_ok & (rx_byte_reg == CMD_RAILS_DETECT);
  assign go_temp = start_ok & (rx_byte_reg == CMD_TEMP_LOAD);

  // Command parser: parameter bytes land by position
  always_comb begin
    cmd_next = cmd_reg;
    pidx_next = pidx_reg;
    lines_next = gate_line_count;
    scan_next = gate_scan_bits;
    glev_next = gate_high_level;
    src_a_next = source_pos_level_a;
    src_b_next = source_pos_level_b;
    src_n_next = source_neg_level;
    thr_next = supply_threshold;
    ss_next = ss_reg;
    if (new_byte && !rx_dc_reg) begin
      cmd_next = rx_byte_reg;
      pidx_next = 3'h0;
    end else if (new_byte && pidx_reg != PARAM_LIMIT) begin
      pidx_next = pidx_reg + 3'h1; // Surplus bytes ignored
      unique case (cmd_reg)
        CMD_GATE_SETUP: begin
          if (pidx_reg == 3'h0) lines_next[7:0] = rx_byte_reg;
          if (pidx_reg == 3'h1) lines_next[8] = rx_byte_reg[0];
          if (pidx_reg == 3'h2) scan_next = rx_byte_reg[2:0];
        end
        CMD_GATE_LEVEL: begin
          if (pidx_reg == 3'h0) glev_next = rx_byte_reg[4:0];
        end
        CMD_SOURCE_LEVEL: begin
          if (pidx_reg == 3'h0) src_a_next = rx_byte_reg;
          if (pidx_reg == 3'h1) src_b_next = rx_byte_reg;
          if (pidx_reg == 3'h2) src_n_next = rx_byte_reg;
        end
        CMD_SOFT_START: begin
          ss_next[pidx_reg[1:0]] = rx_byte_reg;
        end
        CMD_SUPPLY_DETECT: begin
          if (pidx_reg == 3'h0) thr_next = rx_byte_reg[2:0];
        end
        default: begin
        end
      endcase
    end
    // Code checks on the next values
    valid_next[0] = glev_next >= GATE_LEVEL_MIN && glev_next <= GATE_LEVEL_MAX;
    valid_next[1] = src_a_next[RANGE_BIT] ?
      (src_a_next >= SRC_LOW_MIN && src_a_next <= SRC_LOW_MAX) :
      (src_a_next >= SRC_HIGH_MIN && src_a_next <= SRC_HIGH_MAX);
    valid_next[2] = src_b_next[RANGE_BIT] ?
      (src_b_next >= SRC_LOW_MIN && src_b_next <= SRC_LOW_MAX) :
      (src_b_next >= SRC_HIGH_MIN && src_b_next <= SRC_HIGH_MAX);
    valid_next[3] = !src_n_next[0] && src_n_next >= SRC_NEG_MIN &&
      src_n_next <= SRC_NEG_MAX;
    valid_next[4] = thr_next >= SUPPLY_THR_MIN;
  end

  // Settings registers, host-visible state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= 8'h00;
      pidx_reg <= 3'h0;
      gate_line_count <= GATE_LINES_RST;
      gate_scan_bits <= GATE_SCAN_RST;
      gate_high_level <= GATE_LEVEL_RST;
      source_pos_level_a <= SRC_A_RST;
      source_pos_level_b <= SRC_B_RST;
      source_neg_level <= SRC_NEG_RST;
      supply_threshold <= SUPPLY_THR_RST;
      ss_reg <= '{SS_PH1_RST, SS_PH2_RST, SS_PH3_RST, SS_DUR_RST};
      setting_valid <= 5'h1F;
    end else begin
      cmd_reg <= cmd_next;
      pidx_reg <= pidx_next;
      gate_line_count <= lines_next;
      gate_scan_bits <= scan_next;
      gate_high_level <= glev_next;
      source_pos_level_a <= src_a_next;
      source_pos_level_b <= src_b_next;
      source_neg_level <= src_n_next;
      supply_threshold <= thr_next;
      ss_reg <= ss_next;
      setting_valid <= valid_next;
    end
  end

  // Per-phase soft start decode; bit 7 of a phase byte is not checked
  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic [2:0] str_reg, str_next;
    logic [3:0] off_reg, off_next;
    logic ok_reg, ok_next;
    logic [5:0] dur_reg, dur_next;
    always_comb begin
      str_next = ss_reg[p][6:4];
      off_next = ss_reg[p][3:0];
      ok_next = off_next >= OFF_TIME_MIN;
      dur_next = 6'(({4'h0, ss_reg[3][2*p +: 2]} + 6'h01) * DUR_STEP_MS);
    end
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        str_reg <= 3'h0;
        off_reg <= 4'h0;
        ok_reg <= 1'b0;
        dur_reg <= 6'h00;
      end else begin
        str_reg <= str_next;
        off_reg <= off_next;
        ok_reg <= ok_next;
        dur_reg <= dur_next;
      end
    end
    assign ss_strength[3*p +: 3] = str_reg;
    assign ss_off_time[4*p +: 4] = off_reg;
    assign ss_off_valid[p] = ok_reg;
    assign ss_duration_ms[6*p +: 6] = dur_reg;
  end

  // Detection sequencer: fixed window, result caught at its end
  always_comb begin
    det_next = det_reg;
    kind_next = kind_reg;
    dcnt_next = dcnt_reg;
    stat_next = stat_reg;
    unique case (det_reg)
      D_IDLE: begin
        if (go_supply || go_rails) begin
          det_next = D_RUN;
          kind_next = go_rails;
          dcnt_next = 16'(DETECT_N - 1);
        end
      end
      D_RUN: begin
        if (dcnt_reg == 16'h0000) begin
          det_next = D_IDLE;
          if (kind_reg) stat_next[STAT_RAILS_NRDY_BIT] = ~rdy_s2;
          else stat_next[STAT_SUPPLY_LOW_BIT] = low_s2;
        end else begin
          dcnt_next = dcnt_reg - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      det_reg <= D_IDLE;
      kind_reg <= 1'b0;
      dcnt_reg <= 16'h0000;
      stat_reg <= 2'h0;
    end else begin
      det_reg <= det_next;
      kind_reg <= kind_next;
      dcnt_reg <= dcnt_next;
      stat_reg <= stat_next;
    end
  end

  // Sensor read: start, address+read, two bytes, stop; four quarters a bit
  assign addr_byte = {SENSOR_ADDR, 1'b1};
  assign traw = rsh_reg[15:4];
  always_comb begin
    i2c_next = i2c_reg;
    qcnt_next = qcnt_reg - 16'h0001;
    ph_next = ph_reg;
    slot_next = slot_reg;
    rsh_next = rsh_reg;
    sda_oe_n_next = sda_oe_n_reg;
    scl_oe_n_next = scl_oe_n_reg;
    tneg_next = temp_negative;
    tmag_next = temp_magnitude;
    if (i2c_reg == I_IDLE) begin
      qcnt_next = 16'(QTR_N - 1);
      ph_next = 2'h0;
      slot_next = 5'h00;
      if (go_temp) i2c_next = I_START;
    end else if (qcnt_reg == 16'h0000) begin
      qcnt_next = 16'(QTR_N - 1);
      ph_next = ph_reg + 2'h1;
      unique case (i2c_reg)
        I_START: begin
          sda_oe_n_next = (ph_reg == 2'h0); // Data falls, clock high
          // Clock must stay low into the first bit, or data moves while it is high
          scl_oe_n_next = (ph_reg == 2'h0) || (ph_reg == 2'h1);
          if (ph_reg == 2'h3) i2c_next = I_BIT;
        end
        I_BIT: begin
          scl_oe_n_next = (ph_reg == 2'h0) || (ph_reg == 2'h1);
          if (ph_reg == 2'h3) begin
            // Set data for the coming slot while clock is low
            if (slot_reg < SLOT_ADDR_ACK - 5'h01) begin
              sda_oe_n_next = addr_byte[3'h6 - slot_reg[2:0]];
            end else begin
              sda_oe_n_next = (slot_reg != SLOT_MASTER_ACK - 5'h01);
            end
            slot_next = slot_reg + 5'h01;
            if (slot_reg == SLOT_LAST) begin
              i2c_next = I_STOP;
              sda_oe_n_next = 1'b0;
            end
          end
          if (ph_reg == 2'h1 && slot_reg != SLOT_ADDR_ACK && slot_reg != SLOT_MASTER_ACK &&
              slot_reg != SLOT_LAST && slot_reg > SLOT_ADDR_ACK) begin
            rsh_next = {rsh_reg[14:0], sda_s2};
          end
        end
        I_STOP: begin
          scl_oe_n_next = 1'b1;
          sda_oe_n_next = (ph_reg != 2'h0);
          if (ph_reg == 2'h3) begin
            i2c_next = I_IDLE;
            tneg_next = traw[SIGN_BIT];
            tmag_next = traw[SIGN_BIT] ? 12'(~traw + 12'h001) : traw;
          end
        end
        default: begin
        end
      endcase
    end
    // First address bit is driven at the start condition end
    if (i2c_reg == I_START && ph_reg == 2'h3 && qcnt_reg == 16'h0000) begin
      sda_oe_n_next = addr_byte[7];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      i2c_reg <= I_IDLE;
      qcnt_reg <= 16'h0000;
      ph_reg <= 2'h0;
      slot_reg <= 5'h00;
      rsh_reg <= 16'h0000;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
      temp_negative <= 1'b0;
      temp_magnitude <= 12'h000;
    end else begin
      i2c_reg <= i2c_next;
      qcnt_reg <= qcnt_next;
      ph_reg <= ph_next;
      slot_reg <= slot_next;
      rsh_reg <= rsh_next;
      sda_oe_n_reg <= sda_oe_n_next;
      scl_oe_n_reg <= scl_oe_n_next;
      temp_negative <= tneg_next;
      temp_magnitude <= tmag_next;
    end
  end
  // Open drain: only ever pull low
  assign sensor_bus_data_out = 1'b0;
  assign sensor_bus_clock_out = 1'b0;
  assign sensor_bus_data_oe_n = sda_oe_n_reg;
  assign sensor_bus_clock_oe_n = scl_oe_n_reg;

  // Busy covers any running job
  always_comb begin
    busy_next = (det_next != D_IDLE) || (i2c_next != I_IDLE);
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) busy_reg <= 1'b0;
    else busy_reg <= busy_next;
  end
  assign busy = busy_reg;
  assign host_sdo = sdo_reg;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_det_start;
    det_reg == D_IDLE && (go_supply || go_rails);
  endsequence
  sequence s_det_end;
    det_reg == D_RUN && dcnt_reg == 16'h0000;
  endsequence
  a_busy_on_detect: assert property (s_det_start |=> busy)
    else $error("busy not raised by detection");
  a_detect_length: assert property (s_det_start |-> ##DET_N s_det_end ##1 det_reg == D_IDLE)
    else $error("detection window length wrong");
  a_supply_result: assert property (s_det_end and !kind_reg |=>
    stat_reg[STAT_SUPPLY_LOW_BIT] == $past(low_s2))
    else $error("supply result not captured");
  a_rails_result: assert property (s_det_end and kind_reg |=>
    stat_reg[STAT_RAILS_NRDY_BIT] == !$past(rdy_s2))
    else $error("rails result not captured");
  a_temp_sign: assert property (i2c_reg == I_STOP ##1 i2c_reg == I_IDLE |->
    temp_negative == $past(traw[SIGN_BIT], 1))
    else $error("temperature sign wrong");
  a_temp_magnitude: assert property ($changed(temp_magnitude) && temp_negative |->
    12'(temp_magnitude + $past(traw)) == 12'h000)
    else $error("negative magnitude wrong");
  a_gate_valid: assert property (setting_valid[0] |->
    gate_high_level >= GATE_LEVEL_MIN && gate_high_level <= GATE_LEVEL_MAX)
    else $error("gate level flagged valid out of range");
  // Role outputs are registered from the role's next value, so they match role_reg
  a_slave_quiet: assert property (!role_reg |-> shared_osc_clock_pin_oe_n &&
    !osc_enable && !booster_enable)
    else $error("slave drives shared clock");
  a_single_master: assert property (!sensor_bus_data_oe_n |-> i2c_reg != I_IDLE)
    else $error("sensor data pulled while idle");
  a_neg_even: assert property (setting_valid[3] |-> !source_neg_level[0])
    else $error("odd negative code flagged valid");
endmodule

// ===== src/eds_pkg.sv
// Constants for the panel driver setup command block.
// Assumes a 100 MHz core clock and a host that clocks its own serial port.
package eds_pkg;
  // Command codes
  localparam logic [7:0] CMD_GATE_SETUP = 8'h01;
  localparam logic [7:0] CMD_GATE_LEVEL = 8'h03;
  localparam logic [7:0] CMD_SOURCE_LEVEL = 8'h04;
  localparam logic [7:0] CMD_SOFT_START = 8'h0C;
  localparam logic [7:0] CMD_RAILS_DETECT = 8'h14;
  localparam logic [7:0] CMD_SUPPLY_DETECT = 8'h15;
  localparam logic [7:0] CMD_TEMP_LOAD = 8'h20;
  localparam logic [7:0] CMD_STATUS_READ = 8'h2F;
  // Reset values of settings
  localparam logic [8:0] GATE_LINES_RST = 9'h127;
  localparam logic [2:0] GATE_SCAN_RST = 3'h0;
  localparam logic [4:0] GATE_LEVEL_RST = 5'h17;
  localparam logic [7:0] SRC_A_RST = 8'h41;
  localparam logic [7:0] SRC_B_RST = 8'hA8;
  localparam logic [7:0] SRC_NEG_RST = 8'h32;
  localparam logic [7:0] SS_PH1_RST = 8'h8B;
  localparam logic [7:0] SS_PH2_RST = 8'h9C;
  localparam logic [7:0] SS_PH3_RST = 8'h96;
  localparam logic [7:0] SS_DUR_RST = 8'h0F;
  localparam logic [2:0] SUPPLY_THR_RST = 3'h4;
  // Legal code ranges
  localparam logic [4:0] GATE_LEVEL_MIN = 5'h03;
  localparam logic [4:0] GATE_LEVEL_MAX = 5'h17;
  localparam logic [7:0] SRC_LOW_MIN = 8'h8E;
  localparam logic [7:0] SRC_LOW_MAX = 8'hCE;
  localparam logic [7:0] SRC_HIGH_MIN = 8'h23;
  localparam logic [7:0] SRC_HIGH_MAX = 8'h4B;
  localparam logic [7:0] SRC_NEG_MIN = 8'h1A;
  localparam logic [7:0] SRC_NEG_MAX = 8'h3E;
  localparam logic [3:0] OFF_TIME_MIN = 4'h4;
  localparam logic [2:0] SUPPLY_THR_MIN = 3'h3;
  // Field positions
  localparam int RANGE_BIT = 7;
  localparam int SIGN_BIT = 11;
  localparam int STAT_SUPPLY_LOW_BIT = 0;
  localparam int STAT_RAILS_NRDY_BIT = 1;
  // Soft start duration step
  localparam logic [5:0] DUR_STEP_MS = 6'h0A;
  // Timing
  localparam int CORE_CLK_MHZ = 100;
  localparam int DETECT_TIME_NS = 2000;
  localparam int DETECT_CYCLES = (DETECT_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int SCL_QTR_NS = 2500;
  localparam int SCL_QTR_CYCLES = (SCL_QTR_NS * CORE_CLK_MHZ) / 1000;
  // Sensor bus transfer layout, in bit slots; parameter byte limit
  localparam logic [6:0] SENSOR_ADDR = 7'h48;
  localparam logic [4:0] SLOT_ADDR_ACK = 5'h08;
  localparam logic [4:0] SLOT_MASTER_ACK = 5'h11;
  localparam logic [4:0] SLOT_LAST = 5'h1A;
  localparam logic [2:0] PARAM_LIMIT = 3'h4;
endpackage

// ===== tb/eds_host_model.sv
// Host model: sends command and parameter bytes over the serial port.
// Assumes the device samples host_sdi on rising host_sclk, MSB first.
`timescale 1ns/1ps
module eds_host_model (
  // Serial port toward the device
  output logic host_sclk,
  output logic host_cs_n,
  output logic host_dc,
  output logic host_sdi,
  input wire logic host_sdo
);
  // Idle levels; the link clock stands still outside frames
  initial begin
    host_sclk = 1'b0;
    host_cs_n = 1'b1;
    host_dc = 1'b0;
    host_sdi = 1'b1;
  end
  // One frame: a byte out, then nrd bits read back (32 ns link period)
  task automatic frame(input logic dc, input logic [7:0] b, input int nrd,
                       output logic [7:0] rd);
    rd = 8'h00;
    #3 host_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      host_sdi = b[i];
      host_dc = dc;
      #16 host_sclk = 1'b1;
      #16 host_sclk = 1'b0;
    end
    // Read bits: each one sampled just before the next rising edge
    for (int i = 0; i < nrd; i++) begin
      host_sdi = ~host_sdi;
      #16 rd = {rd[6:0], host_sdo};
      host_sclk = 1'b1;
      #16 host_sclk = 1'b0;
    end
    // Deselected: inputs must not keep a stale value
    host_cs_n = 1'b1;
    host_sdi = ~host_sdi;
    host_dc = ~host_dc;
    #64;
  endtask
endmodule

// ===== tb/eds_setup_core_tb_top.sv
// Self-checking bench for the setup command core.
// Assumes the host model drives the serial port in its own clock domain.
`timescale 1ns/1ps
module eds_setup_core_tb_top;
  import eds_pkg::*;
  logic core_clk, resetn, master_strap, supply_below_thr, rails_ready;
  logic host_sclk, host_cs_n, host_dc, host_sdi, host_sdo, busy;
  logic shared_osc_clock_pin_out, shared_osc_clock_pin_oe_n, osc_enable, booster_enable;
  logic clock_from_pin, sensor_bus_clock_out, sensor_bus_clock_oe_n;
  logic sensor_bus_data_out, sensor_bus_data_oe_n, temp_negative;
  logic [8:0] gate_line_count, ss_strength;
  logic [2:0] gate_scan_bits, supply_threshold, ss_off_valid;
  logic [4:0] gate_high_level, setting_valid;
  logic [7:0] source_pos_level_a, source_pos_level_b, source_neg_level;
  logic [11:0] ss_off_time, temp_magnitude;
  logic [17:0] ss_duration_ms;
  // Pulled-up open-drain lines; sda_pull stands in for a sensor holding data low
  logic sda_pull = 1'b0;
  wire logic sensor_bus_clock_in = sensor_bus_clock_oe_n;
  wire logic sensor_bus_data_in = sensor_bus_data_oe_n & ~sda_pull;
  int num_errors = 0;
  int compares = 0;
  eds_setup_core #(.DETECT_N(4), .QTR_N(2)) i_eds_setup_core (.*);
  eds_host_model i_eds_host_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Byte out, then time for the core to take it
  task automatic wr(input logic dc, input logic [7:0] b);
    logic [7:0] rd;
    i_eds_host_model.frame(dc, b, 0, rd);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic st(input logic [7:0] e);
    logic [7:0] rd;
    i_eds_host_model.frame(1'b0, CMD_STATUS_READ, 8, rd);
    chk("status", e, rd);
  endtask
  // Command that raises busy; busy must be seen and then drop
  task automatic cmd_busy(input logic [7:0] c);
    int n;
    logic seen;
    seen = 1'b0;
    fork
      wr(1'b0, c);
      for (n = 0; n < 60; n++) begin
        @(negedge core_clk);
        if (busy === 1'b1) seen = 1'b1;
      end
    join
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge core_clk);
    chk("busy_seen", 1'b1, seen);
    chk("busy_done", 1'b0, busy);
  endtask
  task automatic src(input logic [7:0] a, b, c, input logic [2:0] ok);
    wr(1'b0, CMD_SOURCE_LEVEL);
    wr(1'b1, a);
    wr(1'b1, b);
    wr(1'b1, c);
    chk("src_a", a, source_pos_level_a);
    chk("src_valid", ok, setting_valid[3:1]);
  endtask
  task automatic t_reset_role();
    logic was;
    was = shared_osc_clock_pin_out;
    @(negedge core_clk);
    chk("osc_pin", 1'b1, was ^ shared_osc_clock_pin_out);
    chk("src", {8'h41, 8'hA8}, {source_pos_level_a, source_pos_level_b});
    chk("src_neg", 8'h32, source_neg_level);
    chk("thr", 3'h4, supply_threshold);
    chk("valid", 5'h1F, setting_valid);
    chk("strength", 9'h048, ss_strength);
    chk("off", {12'h6CB, 3'h7}, {ss_off_time, ss_off_valid});
    chk("dur", {6'd10, 6'd40, 6'd40}, ss_duration_ms);
    chk("role_en", 2'h3, {osc_enable, booster_enable});
    chk("role_pin", 2'h0, {clock_from_pin, shared_osc_clock_pin_oe_n});
    chk("bus_idle", 2'h3, {sensor_bus_clock_oe_n, sensor_bus_data_oe_n});
    chk("bus_out", 2'h0, {sensor_bus_clock_out, sensor_bus_data_out});
  endtask
  // Mid-run reset with the strap low: slave role, gate level back to its reset value
  task automatic t_slave();
    resetn = 1'b0;
    master_strap = 1'b0;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("slave_en", 2'h0, {osc_enable, booster_enable});
    chk("slave_pin", 2'h3, {clock_from_pin, shared_osc_clock_pin_oe_n});
    chk("lvl_rst", GATE_LEVEL_RST, gate_high_level);
  endtask
  task automatic t_settings();
    logic [4:0] codes [4] = '{5'h02, 5'h03, 5'h17, 5'h18};
    wr(1'b0, CMD_GATE_SETUP);
    wr(1'b1, 8'h2A);
    wr(1'b1, 8'h01);
    wr(1'b1, 8'h05);
    chk("gate", {9'h12A, 3'h5}, {gate_line_count, gate_scan_bits});
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, CMD_GATE_LEVEL);
      wr(1'b1, {3'h0, codes[i]});
      chk("vgh", {codes[i], i == 1 || i == 2}, {gate_high_level, setting_valid[0]});
    end
    src(8'h8E, 8'h4C, 8'h1B, 3'b001);
    src(8'h8D, 8'h23, 8'h3E, 3'b110);
    src(8'hCE, 8'h4B, 8'h1A, 3'b111);
    wr(1'b0, CMD_SOFT_START);
    wr(1'b1, 8'hF4);
    wr(1'b1, 8'h83);
    wr(1'b1, 8'h8F);
    wr(1'b1, 8'h1B);
    wr(1'b1, 8'h00);
    chk("ss_str", 9'h007, ss_strength);
    chk("ss_off", {12'hF34, 3'b101}, {ss_off_time, ss_off_valid});
    chk("ss_dur", {6'd20, 6'd30, 6'd40}, ss_duration_ms);
  endtask
  task automatic t_detect_temp();
    cmd_busy(CMD_SUPPLY_DETECT);
    wr(1'b1, 8'h02);
    chk("thr", {3'h2, 1'b0}, {supply_threshold, setting_valid[4]});
    st(8'h01);
    rails_ready = 1'b0;
    cmd_busy(CMD_RAILS_DETECT);
    st(8'h03);
    supply_below_thr = 1'b0;
    rails_ready = 1'b1;
    cmd_busy(CMD_SUPPLY_DETECT);
    cmd_busy(CMD_RAILS_DETECT);
    st(8'h00);
    cmd_busy(CMD_TEMP_LOAD);
    chk("temp", {1'b1, 12'h001}, {temp_negative, temp_magnitude});
    sda_pull = 1'b1;
    cmd_busy(CMD_TEMP_LOAD);
    chk("temp_pos", {1'b0, 12'h000}, {temp_negative, temp_magnitude});
    sda_pull = 1'b0;
  endtask
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    resetn = 1'b0;
    master_strap = 1'b1;
    supply_below_thr = 1'b1;
    rails_ready = 1'b1;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    t_reset_role();
    t_settings();
    t_detect_temp();
    t_slave();
    finish_test();
  end
endmodule
